// ### src/serial_link_fault_supervisor.sv
// serial link fault supervisor: retry counter, loss watchdog and fault reaction
//
// Overview of operation
// - count consecutive receive errors; trip once count exceeds retry limit 0 to 10, initial 1.
// - retry limit 9999 never trips; a receive error raises the minor fault alarm instead.
// - output terminals with function 98 drive the alarm high, 198 drive it low.
// - retry limit applies only under the vendor protocol, ignored under Modbus-RTU.
// - interval 0.1 s to 999.8 s trips if silence lasts longer than the interval.
// - interval 9999, the initial value, disables loss detection completely.
// - interval 0 keeps link usable but trips at once on entering link control mode.
// - any received frame clears the loss counter regardless of station number.
// - loss timing starts at the first frame received in link control mode.
// - stop select 0 coasts and latches, 1 decelerates then latches, 2 restarts on removal.
// - retry limit, interval and stop select accept writes only while the gate is 0.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "link_supervisor_consts.svh"
module serial_link_fault_supervisor #(
  parameter int TICK_CYCLES = `LOSS_TICK_CYCLES,
  parameter int ERR_CNT_W   = 4
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // drive side
  input  wire logic        rx_error,
  input  wire logic        frame_valid,
  input  wire logic        link_ctrl_mode,
  input  wire logic        motor_stopped,
  output logic [7:0]       fault_code,
  output logic             fault_display,
  output logic             fault_output,
  output logic             coast_stop,
  output logic             decel_stop,
  output logic             minor_fault_alarm,
  output logic [2:0]       term_out
);

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  logic [15:0]                        retry_limit_setting;
  logic [15:0]                        loss_check_interval;
  link_supervisor_pkg::fault_stop_t   fault_stop_select;
  logic [15:0]                        extended_param_gate;
  logic                               protocol_modbus;
  logic [15:0]                        term_func [3];

  // ----------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        do_write;
  logic        wr_hit;
  logic        wr_ok;
  logic [15:0] wr_val;
  logic        clear_req;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // the transfer completes once both halves are held and no answer is pending
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit && wr_ok) ? 2'h0 : 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // decode and range check; refused values leave the register unchanged
  always_comb begin
    wr_hit = 1'b1;
    wr_ok  = 1'b1;
    wr_val = 16'h0000;
    if (wr_addr == `RETRY_LIMIT_OFS) begin
      wr_val = merge16(retry_limit_setting, wr_data, wr_strb);
      wr_ok  = (extended_param_gate == 16'h0000) &&
               (wr_val <= `RETRY_LIMIT_MAX || wr_val == `SETTING_DISABLED);
    end else if (wr_addr == `LOSS_INTERVAL_OFS) begin
      wr_val = merge16(loss_check_interval, wr_data, wr_strb);
      wr_ok  = (extended_param_gate == 16'h0000) &&
               (wr_val <= `LOSS_INTERVAL_MAX || wr_val == `SETTING_DISABLED);
    end else if (wr_addr == `FAULT_STOP_OFS) begin
      wr_val = merge16({14'h0, fault_stop_select}, wr_data, wr_strb);
      wr_ok  = (extended_param_gate == 16'h0000) && (wr_val <= `FAULT_STOP_MAX);
    end else if (wr_addr == `PARAM_GATE_OFS) begin
      wr_val = merge16(extended_param_gate, wr_data, wr_strb);
    end else if (wr_addr == `PROTOCOL_OFS) begin
      wr_val = merge16({15'h0, protocol_modbus}, wr_data, wr_strb);
    end else if (wr_addr == `TERM_FUNC_A_OFS) begin
      wr_val = merge16(term_func[0], wr_data, wr_strb);
    end else if (wr_addr == `TERM_FUNC_B_OFS) begin
      wr_val = merge16(term_func[1], wr_data, wr_strb);
    end else if (wr_addr == `TERM_FUNC_C_OFS) begin
      wr_val = merge16(term_func[2], wr_data, wr_strb);
    end else if (wr_addr == `CONTROL_OFS) begin
      wr_val = merge16(16'h0000, wr_data, wr_strb);
    end else begin
      wr_hit = 1'b0;
      wr_ok  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // setting registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      retry_limit_setting <= `RETRY_LIMIT_RST;
      loss_check_interval <= `LOSS_INTERVAL_RST;
      fault_stop_select   <= link_supervisor_pkg::fault_stop_t'(`FAULT_STOP_RST);
      extended_param_gate <= `PARAM_GATE_RST;
      protocol_modbus     <= 1'b0;
      term_func[0]        <= `TERM_FUNC_RST;
      term_func[1]        <= `TERM_FUNC_RST;
      term_func[2]        <= `TERM_FUNC_RST;
    end else if (do_write && wr_ok) begin
      if (wr_addr == `RETRY_LIMIT_OFS) begin
        retry_limit_setting <= wr_val;
      end else if (wr_addr == `LOSS_INTERVAL_OFS) begin
        loss_check_interval <= wr_val;
      end else if (wr_addr == `FAULT_STOP_OFS) begin
        fault_stop_select <= link_supervisor_pkg::fault_stop_t'(wr_val[1:0]);
      end else if (wr_addr == `PARAM_GATE_OFS) begin
        extended_param_gate <= wr_val;
      end else if (wr_addr == `PROTOCOL_OFS) begin
        protocol_modbus <= wr_val[`PROTOCOL_MODBUS_BIT];
      end else if (wr_addr == `TERM_FUNC_A_OFS) begin
        term_func[0] <= wr_val;
      end else if (wr_addr == `TERM_FUNC_B_OFS) begin
        term_func[1] <= wr_val;
      end else if (wr_addr == `TERM_FUNC_C_OFS) begin
        term_func[2] <= wr_val;
      end
    end
  end

  assign clear_req = do_write && wr_ok && (wr_addr == `CONTROL_OFS) &&
                     wr_val[`CONTROL_CLEAR_BIT];

  // ----------------------------------------------------------------
  // receive error retry counter
  // ----------------------------------------------------------------
  logic [ERR_CNT_W-1:0] err_count;
  logic                 retry_trip;
  logic                 retry_disabled;
  logic                 frame_ok;

  assign retry_disabled = (retry_limit_setting == `SETTING_DISABLED);
  // a frame flagged with an error in the same cycle does not count as clean
  assign frame_ok       = frame_valid && !rx_error;

  retry_error_counter #(
    .CNT_W        (ERR_CNT_W)
  ) u_retry (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .rx_error     (rx_error),
    .frame_ok     (frame_ok),
    .limit_active (!protocol_modbus && !retry_disabled),
    .limit        (retry_limit_setting),
    .count        (err_count),
    .trip         (retry_trip)
  );

  // alarm holds from the error until the next clean frame or until the retry limit leaves 9999; an error wins a tie
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      minor_fault_alarm <= 1'b0;
    end else if (rx_error && retry_disabled && !protocol_modbus) begin
      minor_fault_alarm <= 1'b1;
    end else if (frame_ok || !retry_disabled) begin
      minor_fault_alarm <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // alarm terminals
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_term
      logic next_term;
      always_comb begin
        next_term = 1'b0;
        if (term_func[gi] == `ALARM_FUNC_POS) begin
          next_term = minor_fault_alarm;
        end else if (term_func[gi] == `ALARM_FUNC_NEG) begin
          next_term = !minor_fault_alarm;
        end
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          term_out[gi] <= 1'b0;
        end else begin
          term_out[gi] <= next_term;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // signal loss watchdog
  // ----------------------------------------------------------------
  logic        loss_armed;
  logic [15:0] loss_count;
  logic        loss_tick;
  logic        loss_trip;
  logic        link_mode_q;
  logic        loss_enabled;

  assign loss_enabled = (loss_check_interval != `SETTING_DISABLED) &&
                        (loss_check_interval != 16'h0000);

  loss_tick_divider #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .restart     (frame_valid || !loss_armed),
    .tick        (loss_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_mode_q <= 1'b0;
    end else begin
      link_mode_q <= link_ctrl_mode;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_armed <= 1'b0;
      loss_count <= 16'h0000;
      loss_trip  <= 1'b0;
    end else begin
      loss_trip <= 1'b0;
      if (!link_ctrl_mode || !loss_enabled) begin
        loss_armed <= 1'b0;
        loss_count <= 16'h0000;
        // interval zero faults on the entry edge into link control
        if (link_ctrl_mode && !link_mode_q && loss_check_interval == 16'h0000) begin
          loss_trip <= 1'b1;
        end
      end else if (frame_valid) begin
        loss_armed <= 1'b1;
        loss_count <= 16'h0000;
      end else if (loss_armed && loss_tick) begin
        if (loss_count >= loss_check_interval - 16'h0001) begin
          loss_trip  <= 1'b1;
          loss_armed <= 1'b0;
          loss_count <= 16'h0000;
        end else begin
          loss_count <= loss_count + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // fault reaction
  // ----------------------------------------------------------------
  link_supervisor_pkg::fault_state_t state;
  link_supervisor_pkg::fault_state_t next_state;
  logic                              trip_event;
  logic                              next_coast;
  logic                              next_display;

  assign trip_event   = retry_trip || loss_trip;
  assign next_coast   = (next_state == link_supervisor_pkg::ST_COAST_HOLD);
  assign next_display = next_coast || (next_state == link_supervisor_pkg::ST_DECEL_HOLD) ||
                        (next_state == link_supervisor_pkg::ST_AUTO_HOLD);

  always_comb begin
    next_state = state;
    case (state)
      link_supervisor_pkg::ST_RUN: begin
        if (trip_event) begin
          if (fault_stop_select == link_supervisor_pkg::STOP_COAST) begin
            next_state = link_supervisor_pkg::ST_COAST_HOLD;
          end else if (fault_stop_select == link_supervisor_pkg::STOP_DECEL) begin
            next_state = link_supervisor_pkg::ST_DECEL;
          end else begin
            next_state = link_supervisor_pkg::ST_AUTO_DECEL;
          end
        end
      end
      link_supervisor_pkg::ST_COAST_HOLD: begin
        if (clear_req) begin
          next_state = link_supervisor_pkg::ST_RUN;
        end
      end
      link_supervisor_pkg::ST_DECEL: begin
        if (motor_stopped) begin
          next_state = link_supervisor_pkg::ST_DECEL_HOLD;
        end
      end
      link_supervisor_pkg::ST_DECEL_HOLD: begin
        if (clear_req) begin
          next_state = link_supervisor_pkg::ST_RUN;
        end
      end
      link_supervisor_pkg::ST_AUTO_DECEL: begin
        // removal during deceleration resumes at once
        if (frame_ok) begin
          next_state = link_supervisor_pkg::ST_RUN;
        end else if (motor_stopped) begin
          next_state = link_supervisor_pkg::ST_AUTO_HOLD;
        end
      end
      link_supervisor_pkg::ST_AUTO_HOLD: begin
        if (frame_ok) begin
          next_state = link_supervisor_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = link_supervisor_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= link_supervisor_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // outputs follow next_state so they change on the same edge as the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coast_stop    <= 1'b0;
      decel_stop    <= 1'b0;
      fault_display <= 1'b0;
      fault_output  <= 1'b0;
      fault_code    <= 8'h00;
    end else begin
      coast_stop    <= next_coast;
      decel_stop    <= (next_state != link_supervisor_pkg::ST_RUN) && !next_coast;
      fault_display <= next_display;
      fault_output  <= next_display && (next_state != link_supervisor_pkg::ST_AUTO_HOLD);
      fault_code    <= next_display ? `LINK_COMM_FAULT_CODE : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic        rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    if (s_axi_araddr == `RETRY_LIMIT_OFS) begin
      rd_val = {16'h0000, retry_limit_setting};
    end else if (s_axi_araddr == `LOSS_INTERVAL_OFS) begin
      rd_val = {16'h0000, loss_check_interval};
    end else if (s_axi_araddr == `FAULT_STOP_OFS) begin
      rd_val = {30'h0, fault_stop_select};
    end else if (s_axi_araddr == `PARAM_GATE_OFS) begin
      rd_val = {16'h0000, extended_param_gate};
    end else if (s_axi_araddr == `PROTOCOL_OFS) begin
      rd_val = {31'h0, protocol_modbus};
    end else if (s_axi_araddr == `TERM_FUNC_A_OFS) begin
      rd_val = {16'h0000, term_func[0]};
    end else if (s_axi_araddr == `TERM_FUNC_B_OFS) begin
      rd_val = {16'h0000, term_func[1]};
    end else if (s_axi_araddr == `TERM_FUNC_C_OFS) begin
      rd_val = {16'h0000, term_func[2]};
    end else if (s_axi_araddr == `STATUS_OFS) begin
      rd_val = {13'h0, state, 4'h0, 4'(err_count), 2'h0, loss_armed,
                minor_fault_alarm, decel_stop, coast_stop, fault_output, fault_display};
    end else if (s_axi_araddr == `CONTROL_OFS) begin
      rd_val = 32'h00000000;
    end else if (s_axi_araddr == `FAULT_CODE_OFS) begin
      rd_val = {24'h000000, fault_code};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### src/link_supervisor_consts.svh
// register offsets, reset values, setting limits and timing for the link fault supervisor
`ifndef LINK_SUPERVISOR_CONSTS_SVH
`define LINK_SUPERVISOR_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RETRY_LIMIT_OFS        8'h00
`define LOSS_INTERVAL_OFS      8'h04
`define FAULT_STOP_OFS         8'h08
`define PARAM_GATE_OFS         8'h0C
`define PROTOCOL_OFS           8'h10
`define TERM_FUNC_A_OFS        8'h14
`define TERM_FUNC_B_OFS        8'h18
`define TERM_FUNC_C_OFS        8'h1C
`define STATUS_OFS             8'h20
`define CONTROL_OFS            8'h24
`define FAULT_CODE_OFS         8'h28

// ----------------------------------------------------------------
// reset values and setting limits
// ----------------------------------------------------------------
`define RETRY_LIMIT_RST        16'h0001
`define RETRY_LIMIT_MAX        16'h000A
`define SETTING_DISABLED       16'h270F
`define LOSS_INTERVAL_RST      16'h270F
`define LOSS_INTERVAL_MAX      16'h270E
`define FAULT_STOP_RST         2'h0
`define FAULT_STOP_MAX         16'h0002
`define PARAM_GATE_RST         16'h0000
`define TERM_FUNC_RST          16'h0000
`define ALARM_FUNC_POS         16'h0062
`define ALARM_FUNC_NEG         16'h00C6
// fault code value is arbitrary
`define LINK_COMM_FAULT_CODE   8'hA5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PROTOCOL_MODBUS_BIT    0
`define CONTROL_CLEAR_BIT      0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ                 20000000
`define LOSS_TICK_MS           100
`define LOSS_TICK_CYCLES       ((`CLK_HZ / 1000) * `LOSS_TICK_MS)

`endif

// ### src/link_supervisor_pkg.sv
// types shared by the link fault supervisor
package link_supervisor_pkg;

  typedef enum logic [1:0] {
    STOP_COAST,
    STOP_DECEL,
    STOP_DECEL_RESTART
  } fault_stop_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_COAST_HOLD,
    ST_DECEL,
    ST_DECEL_HOLD,
    ST_AUTO_DECEL,
    ST_AUTO_HOLD
  } fault_state_t;

endpackage

// ### src/loss_tick_divider.sv
// divider giving one-cycle enable pulses at the loss-check resolution
`timescale 1ns/1ps
module loss_tick_divider #(
  parameter int TICK_CYCLES = 2000000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic restart,
  output logic      tick
);

  logic [31:0] count;

  // restart realigns the phase so a period is measured from the last frame
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      count <= 32'h00000000;
      tick  <= 1'b0;
    end else if (count == 32'(TICK_CYCLES - 1)) begin
      count <= 32'h00000000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick  <= 1'b0;
    end
  end

endmodule

// ### src/retry_error_counter.sv
// consecutive receive error counter with limit check
`timescale 1ns/1ps
module retry_error_counter #(
  parameter int CNT_W = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             rx_error,
  input  wire logic             frame_ok,
  input  wire logic             limit_active,
  input  wire logic [15:0]      limit,
  output logic      [CNT_W-1:0] count,
  output logic                  trip
);

  logic [CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (rx_error && count != {CNT_W{1'b1}}) begin
      next_count = count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      trip  <= 1'b0;
    end else begin
      trip <= 1'b0;
      if (frame_ok) begin
        count <= '0;
      end else if (rx_error) begin
        count <= next_count;
        if (limit_active && 16'(next_count) > limit) begin
          trip <= 1'b1;
        end
      end
    end
  end

endmodule

// ### test/link_host_model.sv
// behavioural serial link master feeding frame pulses to the supervisor
`timescale 1ns/1ps
module link_host_model (
  input  wire logic aclk,
  output logic      frame_valid,
  output logic      rx_error
);
  initial begin
    frame_valid = 1'h0;
    rx_error    = 1'h0;
  end
  // one frame; the idle edge after it keeps back-to-back frames apart
  task send(input logic err);
    frame_valid <= 1'h1;
    rx_error    <= err;
    @(posedge aclk);
    frame_valid <= 1'h0;
    rx_error    <= 1'h0;
    @(posedge aclk);
  endtask
  task keep(input int n);
    repeat (n) begin
      repeat (8) @(posedge aclk);
      send(1'h0);
    end
  endtask
endmodule

// ### test/serial_link_fault_supervisor_chk.sv
// port assertions for the link fault supervisor
`timescale 1ns/1ps
`include "link_supervisor_consts.svh"
module link_sup_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       rx_error,
  input wire logic       frame_valid,
  input wire logic [7:0] fault_code,
  input wire logic       fault_display,
  input wire logic       fault_output,
  input wire logic       coast_stop,
  input wire logic       decel_stop,
  input wire logic       minor_fault_alarm
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_clean; frame_valid && !rx_error; endsequence
  property p_code; fault_code == (fault_display ? `LINK_COMM_FAULT_CODE : 8'h00); endproperty
  a_code: assert property (p_code) else $error("fault code wrong");
  property p_out; fault_output |-> fault_display; endproperty
  a_out: assert property (p_out) else $error("output without display");
  property p_coast; $rose(coast_stop) |-> fault_display && fault_output; endproperty
  a_coast: assert property (p_coast) else $error("coast without fault");
  property p_excl; !(coast_stop && decel_stop); endproperty
  a_excl: assert property (p_excl) else $error("coast and decel");
  property p_alarm; $rose(minor_fault_alarm) |-> $past(rx_error); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm without error");
  property p_alclr; minor_fault_alarm ##0 s_clean |=> !minor_fault_alarm; endproperty
  a_alclr: assert property (p_alclr) else $error("alarm kept");
  property p_rd; s_rd |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read late");
  property p_bv; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bv: assert property (p_bv) else $error("response dropped");
endmodule
bind serial_link_fault_supervisor link_sup_chk chk_i (.*);

// ### test/serial_link_fault_supervisor_tb.sv
// self-checking bench for the link fault supervisor
`timescale 1ns/1ps
`include "link_supervisor_consts.svh"
module serial_link_fault_supervisor_tb;
  logic        aclk = 1'h0, aresetn, link_ctrl_mode, motor_stopped;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fault_code;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  term_out;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready = 1'h0;
  logic        s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rx_error, frame_valid, fault_display, fault_output, coast_stop, decel_stop;
  logic        minor_fault_alarm;
  int          fails = 0, checks = 0;
  always #25 aclk = ~aclk;
  serial_link_fault_supervisor #(.TICK_CYCLES(10)) dut (.*);
  link_host_model host (.*);
  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, e, input string nm);
    checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task tmo(input int n);
    if (n == 50) begin
      fails++;
      end_of_test();
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task fl(input logic [4:0] e);
    chk({fault_display, fault_output, coast_stop, decel_stop, minor_fault_alarm}, e, "flags");
  endtask
  // ----------------------------------------------------------------
  // register bus; bready comes late so the held response is exercised
  // ----------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (!s_axi_bready) s_axi_bready <= n > 2;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, r, "bresp");
    tmo(n);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    chk(s_axi_rdata, e, "rdata");
    chk(s_axi_rresp, r, "rresp");
    tmo(n);
  endtask
  task t_reg;
    rd(8'h00, 32'h1, 2'h0);
    rd(8'h04, 32'h270F, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h0C, 32'h1, 2'h0);
    wr(8'h00, 32'h5, 2'h2);
    wr(8'h0C, 32'h0, 2'h0);
    s_axi_wstrb <= 4'h2;
    wr(8'h00, 32'h5, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h00, 32'h1, 2'h0);
    $display("t_reg done");
  endtask
  task t_retry;
    host.send(1'h1);
    host.send(1'h0);
    host.send(1'h1);
    cyc(2);
    fl(5'h00);
    host.send(1'h1);
    cyc(2);
    fl(5'h1C);
    chk(fault_code, `LINK_COMM_FAULT_CODE, "code");
    wr(8'h24, 32'h1, 2'h0);
    cyc(2);
    fl(5'h00);
    $display("t_retry done");
  endtask
  task t_alarm;
    wr(8'h00, 32'h270F, 2'h0);
    wr(8'h14, 32'h62, 2'h0);
    wr(8'h18, 32'hC6, 2'h0);
    host.send(1'h1);
    host.send(1'h1);
    cyc(2);
    fl(5'h01);
    chk(term_out, 32'h1, "term");
    host.send(1'h0);
    cyc(2);
    chk(term_out, 32'h2, "term");
    wr(8'h10, 32'h1, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    host.send(1'h1);
    cyc(2);
    fl(5'h00);
    wr(8'h00, 32'h270F, 2'h0);
    wr(8'h10, 32'h0, 2'h0);
    $display("t_alarm done");
  endtask
  task t_loss;
    link_ctrl_mode <= 1'h1;
    host.send(1'h0);
    cyc(40);
    fl(5'h00);
    wr(8'h08, 32'h1, 2'h0);
    wr(8'h04, 32'h2, 2'h0);
    cyc(40);
    fl(5'h00);
    host.keep(5);
    cyc(15);
    fl(5'h00);
    cyc(10);
    fl(5'h02);
    motor_stopped <= 1'h1;
    cyc(3);
    fl(5'h1A);
    wr(8'h24, 32'h1, 2'h0);
    motor_stopped <= 1'h0;
    link_ctrl_mode <= 1'h0;
    $display("t_loss done");
  endtask
  task t_zero;
    wr(8'h08, 32'h2, 2'h0);
    wr(8'h04, 32'h0, 2'h0);
    link_ctrl_mode <= 1'h1;
    cyc(4);
    fl(5'h02);
    motor_stopped <= 1'h1;
    cyc(3);
    fl(5'h12);
    host.send(1'h0);
    cyc(2);
    fl(5'h00);
    $display("t_zero done");
  endtask
  initial begin
    {aresetn, link_ctrl_mode, motor_stopped, s_axi_wstrb} <= 7'h0F;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} <= 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_reg();
    t_retry();
    t_alarm();
    t_loss();
    t_zero();
    end_of_test();
  end
endmodule
